/* shared/dmbo_cfg.svh */
// Constants of the data move and bit operation executor.
// Assumes one core clock and a register file of 32 bytes.
//
// How it works
// - Post-increment store writes, then bumps pointer
// - Pre-decrement store drops pointer, then writes
// - Offset store uses selected X/Y/Z pointer plus displacement
// - Direct store uses instruction address constant
// - Push writes register to stack, two cycles
// - Pop loads register from stack, two cycles
// - I/O bit set forces one bit high
// - I/O bit clear forces one bit low
// - Left shift fills zero, sets Z C N V
// - Right shift fills zero, sets Z C N V
// - Left rotate moves carry through bit 0
// - Right rotate moves carry through bit 7
// - Signed right shift keeps bit 7
// - Bit copy into transfer flag
// - Transfer flag copied into register bit
// - Overflow flag set and clear alone
// - Sign flag set and clear alone
// - Half carry flag set and clear alone
// - Watchdog restart pulse, flags untouched
`ifndef DMBO_CFG_SVH
`define DMBO_CFG_SVH

// Flag positions in the cpu_flag_register
`define DMBO_FLG_C     3'd0
`define DMBO_FLG_Z     3'd1
`define DMBO_FLG_N     3'd2
`define DMBO_FLG_V     3'd3
`define DMBO_FLG_S     3'd4
`define DMBO_FLG_H     3'd5
`define DMBO_FLG_T     3'd6
`define DMBO_FLG_I     3'd7

// Reset values
`define DMBO_FLAGS_RST 8'h00
`define DMBO_SP_RST    16'h00ff

// Cycles taken by the two kinds of operation
`define DMBO_CYC_MEM   2
`define DMBO_CYC_ALU   1

`endif

/* shared/dmbo_pkg.sv */
// Types of the data move and bit operation executor.
// Assumes the constants header is compiled alongside.
package dmbo_pkg;

   // Operation codes presented on OP_CODE_I
   typedef enum logic [4:0] {
      OP_NONE         = 5'h00,
      OP_IND_WRITE    = 5'h01, // indirect_memory_write, pointer kept
      OP_IND_POSTINC  = 5'h02, // indirect_memory_write, post-increment
      OP_IND_PREDEC   = 5'h03, // indirect_memory_write, pre-decrement
      OP_OFFSET_WRITE = 5'h04, // offset_memory_write
      OP_DIRECT_WRITE = 5'h05, // direct_memory_write
      OP_PUSH         = 5'h06,
      OP_POP          = 5'h07,
      OP_IO_BIT_SET   = 5'h08, // io_bit_set
      OP_IO_BIT_CLEAR = 5'h09, // io_bit_clear
      OP_SHL_ZERO     = 5'h0a, // shift_left_zero_fill
      OP_SHR_ZERO     = 5'h0b, // shift_right_zero_fill
      OP_ROL_CARRY    = 5'h0c, // rotate_left_via_carry
      OP_ROR_CARRY    = 5'h0d, // rotate_right_via_carry
      OP_SIGNED_SHR   = 5'h0e, // signed_shift_right
      OP_BIT_TO_T     = 5'h0f, // copy_bit_to_transfer_flag
      OP_T_TO_BIT     = 5'h10, // copy_transfer_flag_to_bit
      OP_FLAG_SET     = 5'h11, // any single flag, index on BIT_I
      OP_FLAG_CLEAR   = 5'h12,
      OP_WDOG_RESTART = 5'h13  // watchdog_restart
   } dmbo_op_type;

   // One-hot sequencer states
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_MEM  = 3'b010,
      S_IO   = 3'b100
   } dmbo_state_type;

   // Whole state of the executor
   typedef struct packed {
      dmbo_state_type  st;
      logic [31:0][7:0] rf;
      logic [7:0]      flags;
      logic [15:0]     sp;
      dmbo_op_type     op;
      logic [4:0]      rsel;
      logic [2:0]      bsel;
      logic [1:0]      psel;
      logic [15:0]     ptr_new;
      logic            dm_we;
      logic            dm_re;
      logic [15:0]     dm_addr;
      logic [7:0]      dm_wdata;
      logic            io_re;
      logic            io_we;
      logic [4:0]      io_addr;
      logic [7:0]      io_wdata;
      logic            wdt;
      logic            done;
      logic            busy;
      logic [7:0]      rf_rdata;
   } dmbo_regs_type;

endpackage : dmbo_pkg

/* src/dmbo_exec.sv */
// Executor for stores, stack, I/O bit, shift/rotate and flag operations.
// Assumes a data memory and I/O space that answer reads in the same cycle.
`include "dmbo_cfg.svh"

module dmbo_exec
   import dmbo_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_N_I,
   // Operation request
   input  wire logic        OP_VALID_I,
   input  wire logic [4:0]  OP_CODE_I,
   input  wire logic [4:0]  REG_I,
   input  wire logic [1:0]  PTR_SEL_I,
   input  wire logic [5:0]  DISP_I,
   input  wire logic [15:0] ADDR_I,
   input  wire logic [4:0]  IO_ADDR_I,
   input  wire logic [2:0]  BIT_I,
   // Operation status
   output wire logic        BUSY_O,
   output wire logic        DONE_O,
   // Register file access port
   input  wire logic        RF_WE_I,
   input  wire logic [4:0]  RF_WADDR_I,
   input  wire logic [7:0]  RF_WDATA_I,
   input  wire logic [4:0]  RF_RADDR_I,
   output wire logic [7:0]  RF_RDATA_O,
   // Data memory
   output wire logic        DM_WE_O,
   output wire logic        DM_RE_O,
   output wire logic [15:0] DM_ADDR_O,
   output wire logic [7:0]  DM_WDATA_O,
   input  wire logic [7:0]  DM_RDATA_I,
   // I/O space
   output wire logic        IO_RE_O,
   output wire logic        IO_WE_O,
   output wire logic [4:0]  IO_ADDR_O,
   output wire logic [7:0]  IO_WDATA_O,
   input  wire logic [7:0]  IO_RDATA_I,
   // Status flags and watchdog
   output wire logic [7:0]  FLAGS_O,
   output wire logic        WDT_RESTART_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Low register of pointer pair: 1 X, 2 Y, 3 Z
   function automatic logic [4:0] ptr_idx(input logic [1:0] sel);
      ptr_idx = {2'b11, sel, 1'b0};
   endfunction : ptr_idx

   // 16-bit pointer read from its register pair
   function automatic logic [15:0] ptr_get(input logic [31:0][7:0] rf,
                                           input logic [1:0]       sel);
      logic [4:0] lo;
      lo      = ptr_idx(sel);
      ptr_get = {rf[lo + 5'd1], rf[lo]};
   endfunction : ptr_get

   // Flags after a shift or rotate: Z C N V, others kept
   function automatic logic [7:0] shf_flags(input logic [7:0] f,
                                            input logic [7:0] res,
                                            input logic       c);
      shf_flags                = f;
      shf_flags[`DMBO_FLG_Z]   = (res == 8'h00);
      shf_flags[`DMBO_FLG_C]   = c;
      shf_flags[`DMBO_FLG_N]   = res[7];
      shf_flags[`DMBO_FLG_V]   = res[7] ^ c;
   endfunction : shf_flags

   ////////////////////////////////////////////////////////////////////////////
   // State

   dmbo_regs_type q;        // Registered state
   dmbo_regs_type d;        // Next state
   logic          acc;      // Request taken this cycle
   logic [15:0]   cur_ptr;  // Pointer named by the request
   logic [7:0]    src;      // Register named by the request
   logic [7:0]    res;      // Shift result
   logic [7:0]    mask;     // One-hot bit mask
   logic [4:0]    lo;       // Pointer pair low index on write-back
   logic          c_in;     // Carry before the operation

   assign acc     = OP_VALID_I && (q.st == S_IDLE);
   assign cur_ptr = ptr_get(q.rf, PTR_SEL_I);
   assign src     = q.rf[REG_I];
   assign c_in    = q.flags[`DMBO_FLG_C];

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      d        = q;
      res      = 8'h00;
      mask     = 8'h01 << BIT_I;
      lo       = ptr_idx(q.psel);
      // Strobes last one cycle
      d.dm_we  = 1'b0;
      d.dm_re  = 1'b0;
      d.io_re  = 1'b0;
      d.io_we  = 1'b0;
      d.wdt    = 1'b0;
      d.done   = 1'b0;
      // Outside register port; executor writes below take priority
      if (RF_WE_I) begin
         d.rf[RF_WADDR_I] = RF_WDATA_I;
      end
      d.rf_rdata = q.rf[RF_RADDR_I];
      case (q.st)
         // Take a request and do its first cycle
         S_IDLE: begin
            if (OP_VALID_I) begin
               d.op       = dmbo_op_type'(OP_CODE_I);
               d.rsel     = REG_I;
               d.bsel     = BIT_I;
               d.psel     = PTR_SEL_I;
               d.ptr_new  = cur_ptr;
               d.dm_wdata = src;
               case (dmbo_op_type'(OP_CODE_I))
                  OP_IND_WRITE: begin
                     d.dm_we   = 1'b1;
                     d.dm_addr = cur_ptr;
                     d.st      = S_MEM;
                  end
                  OP_IND_POSTINC: begin
                     d.dm_we   = 1'b1;
                     d.dm_addr = cur_ptr;
                     d.ptr_new = cur_ptr + 16'h0001;
                     d.st      = S_MEM;
                  end
                  OP_IND_PREDEC: begin
                     d.dm_we   = 1'b1;
                     d.dm_addr = cur_ptr - 16'h0001;
                     d.ptr_new = cur_ptr - 16'h0001;
                     d.st      = S_MEM;
                  end
                  OP_OFFSET_WRITE: begin
                     d.dm_we   = 1'b1;
                     d.dm_addr = cur_ptr + {10'h000, DISP_I};
                     d.st      = S_MEM;
                  end
                  OP_DIRECT_WRITE: begin
                     d.dm_we   = 1'b1;
                     d.dm_addr = ADDR_I;
                     d.st      = S_MEM;
                  end
                  OP_PUSH: begin
                     // Write at stack pointer, then move it down
                     d.dm_we   = 1'b1;
                     d.dm_addr = q.sp;
                     d.sp      = q.sp - 16'h0001;
                     d.st      = S_MEM;
                  end
                  OP_POP: begin
                     // Move the stack pointer up, then read there
                     d.dm_re   = 1'b1;
                     d.dm_addr = q.sp + 16'h0001;
                     d.sp      = q.sp + 16'h0001;
                     d.st      = S_MEM;
                  end
                  OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
                     // Read the I/O register first
                     d.io_re   = 1'b1;
                     d.io_addr = IO_ADDR_I;
                     d.st      = S_IO;
                  end
                  OP_SHL_ZERO: begin
                     res        = {src[6:0], 1'b0};
                     d.rf[REG_I] = res;
                     d.flags    = shf_flags(q.flags, res, src[7]);
                     d.done     = 1'b1;
                  end
                  OP_SHR_ZERO: begin
                     res        = {1'b0, src[7:1]};
                     d.rf[REG_I] = res;
                     d.flags    = shf_flags(q.flags, res, src[0]);
                     d.done     = 1'b1;
                  end
                  OP_ROL_CARRY: begin
                     res        = {src[6:0], c_in};
                     d.rf[REG_I] = res;
                     d.flags    = shf_flags(q.flags, res, src[7]);
                     d.done     = 1'b1;
                  end
                  OP_ROR_CARRY: begin
                     res        = {c_in, src[7:1]};
                     d.rf[REG_I] = res;
                     d.flags    = shf_flags(q.flags, res, src[0]);
                     d.done     = 1'b1;
                  end
                  OP_SIGNED_SHR: begin
                     res        = {src[7], src[7:1]};
                     d.rf[REG_I] = res;
                     d.flags    = shf_flags(q.flags, res, src[0]);
                     d.done     = 1'b1;
                  end
                  OP_BIT_TO_T: begin
                     d.flags[`DMBO_FLG_T] = src[BIT_I];
                     d.done               = 1'b1;
                  end
                  OP_T_TO_BIT: begin
                     d.rf[REG_I][BIT_I] = q.flags[`DMBO_FLG_T];
                     d.done             = 1'b1;
                  end
                  OP_FLAG_SET: begin
                     // One flag only, e.g. V, S or H
                     d.flags = q.flags | mask;
                     d.done  = 1'b1;
                  end
                  OP_FLAG_CLEAR: begin
                     d.flags = q.flags & ~mask;
                     d.done  = 1'b1;
                  end
                  OP_WDOG_RESTART: begin
                     d.wdt  = 1'b1;
                     d.done = 1'b1;
                  end
                  default: begin
                     // Unknown code: completes with no effect
                     d.done = 1'b1;
                  end
               endcase
            end
         end
         // Second cycle of a memory operation
         S_MEM: begin
            if (q.op == OP_POP) begin
               d.rf[q.rsel] = DM_RDATA_I;
            end
            if ((q.op == OP_IND_POSTINC) || (q.op == OP_IND_PREDEC)) begin
               d.rf[lo]        = q.ptr_new[7:0];
               d.rf[lo + 5'd1] = q.ptr_new[15:8];
            end
            d.done = 1'b1;
            d.st   = S_IDLE;
         end
         // Second cycle of an I/O bit operation: write back
         S_IO: begin
            d.io_we = 1'b1;
            if (q.op == OP_IO_BIT_SET) begin
               d.io_wdata = IO_RDATA_I | (8'h01 << q.bsel);
            end else begin
               d.io_wdata = IO_RDATA_I & ~(8'h01 << q.bsel);
            end
            d.done = 1'b1;
            d.st   = S_IDLE;
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase
      d.busy = (d.st != S_IDLE); // Busy pin leaves a flop
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         q       <= '0;
         q.st    <= S_IDLE;
         q.op    <= OP_NONE;
         q.flags <= `DMBO_FLAGS_RST;
         q.sp    <= `DMBO_SP_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign BUSY_O        = q.busy;
   assign DONE_O        = q.done;
   assign RF_RDATA_O    = q.rf_rdata;
   assign DM_WE_O       = q.dm_we;
   assign DM_RE_O       = q.dm_re;
   assign DM_ADDR_O     = q.dm_addr;
   assign DM_WDATA_O    = q.dm_wdata;
   assign IO_RE_O       = q.io_re;
   assign IO_WE_O       = q.io_we;
   assign IO_ADDR_O     = q.io_addr;
   assign IO_WDATA_O    = q.io_wdata;
   assign FLAGS_O       = q.flags;
   assign WDT_RESTART_O = q.wdt;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);

   property p_postinc;
      (acc && OP_CODE_I == OP_IND_POSTINC && !RF_WE_I) |=>
         (DM_WE_O && DM_ADDR_O == $past(cur_ptr) && DM_WDATA_O == $past(src))
         ##1 (DONE_O && ptr_get(q.rf, q.psel) == DM_ADDR_O + 16'h0001);
   endproperty
   a_postinc: assert property (p_postinc) else $error("post-increment store");

   property p_predec;
      (acc && OP_CODE_I == OP_IND_PREDEC && !RF_WE_I) |=>
         (DM_WE_O && DM_ADDR_O == $past(cur_ptr) - 16'h0001)
         ##1 (DONE_O && ptr_get(q.rf, q.psel) == DM_ADDR_O);
   endproperty
   a_predec: assert property (p_predec) else $error("pre-decrement store");

   property p_offset;
      (acc && OP_CODE_I == OP_OFFSET_WRITE) |=>
         DM_WE_O && DM_ADDR_O == $past(cur_ptr) + {10'h000, $past(DISP_I)};
   endproperty
   a_offset: assert property (p_offset) else $error("offset store address");

   property p_direct;
      (acc && OP_CODE_I == OP_DIRECT_WRITE) |=>
         (DM_WE_O && DM_ADDR_O == $past(ADDR_I)) ##1
         (DONE_O && !DM_WE_O && $stable(FLAGS_O));
   endproperty
   a_direct: assert property (p_direct) else $error("direct store");

   property p_io_set;
      (acc && OP_CODE_I == OP_IO_BIT_SET) |=>
         IO_RE_O ##1 (IO_WE_O && DONE_O && IO_WDATA_O[q.bsel]);
   endproperty
   a_io_set: assert property (p_io_set) else $error("I/O bit set");

   property p_io_clear;
      (acc && OP_CODE_I == OP_IO_BIT_CLEAR) |=>
         IO_RE_O ##1 (IO_WE_O && !IO_WDATA_O[q.bsel]);
   endproperty
   a_io_clear: assert property (p_io_clear) else $error("I/O bit clear");

   property p_shl;
      (acc && OP_CODE_I == OP_SHL_ZERO) |=>
         DONE_O && q.rf[q.rsel] == {$past(src[6:0]), 1'b0}
         && FLAGS_O[`DMBO_FLG_C] == $past(src[7]);
   endproperty
   a_shl: assert property (p_shl) else $error("left shift");

   property p_ror;
      (acc && OP_CODE_I == OP_ROR_CARRY) |=>
         q.rf[q.rsel] == {$past(c_in), $past(src[7:1])}
         && FLAGS_O[`DMBO_FLG_C] == $past(src[0]);
   endproperty
   a_ror: assert property (p_ror) else $error("right rotate");

   property p_t_to_bit;
      (acc && OP_CODE_I == OP_T_TO_BIT) |=>
         q.rf[q.rsel][q.bsel] == FLAGS_O[`DMBO_FLG_T] && $stable(FLAGS_O);
   endproperty
   a_t_to_bit: assert property (p_t_to_bit) else $error("bit load");

   property p_flag_set;
      (acc && OP_CODE_I == OP_FLAG_SET) |=>
         FLAGS_O == ($past(FLAGS_O) | (8'h01 << $past(BIT_I)));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag set");

   property p_wdog;
      (acc && OP_CODE_I == OP_WDOG_RESTART) |=>
         WDT_RESTART_O && $stable(FLAGS_O) ##1 !WDT_RESTART_O;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog restart");

endmodule : dmbo_exec

/* verification/dmbo_mem_model.sv */
// Behavioural data memory and I/O space facing the executor.
// Assumes one-cycle strobes and reads answered inside the strobe cycle.
module dmbo_mem_model (
   // Clock
   input  wire logic        clk_sys_i,
   // Data memory side
   input  wire logic        dm_we_i,
   input  wire logic        dm_re_i,
   input  wire logic [15:0] dm_addr_i,
   input  wire logic [7:0]  dm_wdata_i,
   output wire logic [7:0]  dm_rdata_o,
   // I/O side
   input  wire logic        io_re_i,
   input  wire logic        io_we_i,
   input  wire logic [4:0]  io_addr_i,
   input  wire logic [7:0]  io_wdata_i,
   output wire logic [7:0]  io_rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_q [65536]; // Data memory contents
   logic [7:0] io_q  [32];    // I/O registers, known start pattern
   logic [7:0] dm_last_q;     // Last data memory read
   logic [7:0] io_last_q;     // Last I/O read
   ////////////////////////////////////////////////////////////////////////
   // Start pattern that the bench mirrors
   initial begin
      dm_last_q = 8'h00;
      io_last_q = 8'h00;
      for (int i = 0; i < 32; i++) begin
         io_q[i] = 8'ha0 ^ 8'(i);
      end
   end
   // Idle read lines show the inverse of the last read, never stale data
   assign dm_rdata_o = dm_re_i ? mem_q[dm_addr_i] : ~dm_last_q;
   assign io_rdata_o = io_re_i ? io_q[io_addr_i] : ~io_last_q;
   // Writes and read history at the clock edge
   always @(posedge clk_sys_i) begin
      if (dm_we_i) begin
         mem_q[dm_addr_i] <= dm_wdata_i;
      end
      if (io_we_i) begin
         io_q[io_addr_i] <= io_wdata_i;
      end
      if (dm_re_i) begin
         dm_last_q <= mem_q[dm_addr_i];
      end
      if (io_re_i) begin
         io_last_q <= io_q[io_addr_i];
      end
   end
endmodule : dmbo_mem_model

/* verification/dmbo_exec_tb_top.sv */
// Self-checking bench of the data move and bit operation executor.
// Assumes the package, the constants header and the memory model compiled first.
`include "dmbo_cfg.svh"
module dmbo_exec_tb_top
   import dmbo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Stimulus
   logic        clk, rst_n, op_valid, rf_we;
   logic [4:0]  op_code, reg_sel, io_addr, rf_waddr, rf_raddr;
   logic [1:0]  ptr_sel;
   logic [5:0]  disp;
   logic [15:0] addr;
   logic [2:0]  bit_sel;
   logic [7:0]  rf_wdata;
   // Observed outputs
   logic        busy, done, dm_we, dm_re, io_re, io_we, wdt;
   logic [7:0]  rf_rdata, dm_wdata, dm_rdata, io_wdata, io_rdata, flags;
   logic [15:0] dm_addr;
   logic [4:0]  io_port;
   // Checking state
   int          mismatches, n_compared, cycles;
   logic [31:0] lfsr_q;     // Random source
   logic [7:0]  rm [32];    // Register file model
   logic [7:0]  iom [32];   // I/O register model
   logic [7:0]  fl;         // Flag model
   logic [7:0]  t, u, v;
   logic [2:0]  b;
   logic [15:0] a;
   logic [8:0]  q_flg [$];  // {watchdog, flags} per completion
   logic [24:0] q_dm [$];   // {write, address, data} per strobe
   logic [12:0] q_io [$];   // {address, data} per I/O write
   dmbo_exec dut_u (
      .CLK_SYS_I(clk), .RST_N_I(rst_n), .OP_VALID_I(op_valid), .OP_CODE_I(op_code),
      .REG_I(reg_sel), .PTR_SEL_I(ptr_sel), .DISP_I(disp), .ADDR_I(addr),
      .IO_ADDR_I(io_addr), .BIT_I(bit_sel), .BUSY_O(busy), .DONE_O(done),
      .RF_WE_I(rf_we), .RF_WADDR_I(rf_waddr), .RF_WDATA_I(rf_wdata), .RF_RADDR_I(rf_raddr),
      .RF_RDATA_O(rf_rdata), .DM_WE_O(dm_we), .DM_RE_O(dm_re), .DM_ADDR_O(dm_addr),
      .DM_WDATA_O(dm_wdata), .DM_RDATA_I(dm_rdata), .IO_RE_O(io_re), .IO_WE_O(io_we),
      .IO_ADDR_O(io_port), .IO_WDATA_O(io_wdata), .IO_RDATA_I(io_rdata),
      .FLAGS_O(flags), .WDT_RESTART_O(wdt));
   dmbo_mem_model mem_u (
      .clk_sys_i(clk), .dm_we_i(dm_we), .dm_re_i(dm_re), .dm_addr_i(dm_addr),
      .dm_wdata_i(dm_wdata), .dm_rdata_o(dm_rdata), .io_re_i(io_re), .io_we_i(io_we),
      .io_addr_i(io_port), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata));
   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   // Verdict; expectations never consumed count as mismatches
   task automatic tally_and_finish();
      mismatches += q_flg.size() + q_dm.size() + q_io.size();
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   task automatic note(input string what, input logic [24:0] e, input logic [24:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : note
   task automatic cmp_flags(input logic [9:0] e, input logic [9:0] g);
      note("busy, flags and watchdog", 25'(e), 25'(g));
   endtask : cmp_flags
   task automatic cmp_mem(input logic [24:0] e, input logic [24:0] g);
      note("memory strobe", e, g);
   endtask : cmp_mem
   task automatic cmp_io(input logic [12:0] e, input logic [12:0] g);
      note("I/O write", 25'(e), 25'(g));
   endtask : cmp_io
   task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
      note("register", 25'(e), 25'(g));
   endtask : cmp_reg
   // Watcher: each appearing result takes the oldest note of its kind
   always @(negedge clk) begin
      if (rst_n === 1'b1 && done === 1'b1) begin
         cmp_flags({1'b0, q_flg.pop_front()}, {busy, wdt, flags});
      end
      if (dm_we === 1'b1 || dm_re === 1'b1) begin
         cmp_mem(q_dm.pop_front(), {dm_we, dm_addr, dm_we ? dm_wdata : 8'h00});
      end
      if (io_we === 1'b1) begin
         cmp_io(q_io.pop_front(), {io_port, io_wdata});
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Random bytes from a 32-bit shift register
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[7:0];
   endfunction : rnd
   // Shift model; updates Z C N V of the flag model, V is N xor C
   function automatic logic [7:0] shift_model(input logic [4:0] c, input logic [7:0] x);
      logic [7:0] r;
      logic       cy;
      case (c)
         OP_SHL_ZERO:  {cy, r} = {x, 1'b0};
         OP_SHR_ZERO:  {r, cy} = {1'b0, x};
         OP_ROL_CARRY: {cy, r} = {x, fl[0]};
         OP_ROR_CARRY: {r, cy} = {fl[0], x};
         default:      {r, cy} = {x[7], x};
      endcase
      fl[3:0] = {r[7] ^ cy, r[7], r == 8'h00, cy};
      return r;
   endfunction : shift_model
   // Register write through the outside port, idle edge after
   task automatic wr_reg(input logic [4:0] i, input logic [7:0] x);
      rf_we    <= 1'b1;
      rf_waddr <= i;
      rf_wdata <= x;
      rm[i] = x;
      @(posedge clk);
      rf_we <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   // Registered read, data one cycle after the address
   task automatic chk_reg(input logic [4:0] i);
      rf_raddr <= i;
      @(posedge clk);
      @(negedge clk);
      cmp_reg(rm[i], rf_rdata);
      @(posedge clk);
   endtask : chk_reg
   // One request, held to the taking edge, then wait for completion
   task automatic do_op(input logic [4:0] c, input logic [4:0] r, input logic [1:0] p,
                        input logic [2:0] k, input logic [15:0] ad, input logic [5:0] d,
                        input logic [4:0] io);
      int n;
      q_flg.push_back({c == OP_WDOG_RESTART, fl});
      {op_valid, op_code, reg_sel, ptr_sel, bit_sel} <= {1'b1, c, r, p, k};
      {addr, disp, io_addr} <= {ad, d, io};
      @(posedge clk);
      op_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (done !== 1'b1 && n < 8);
      @(posedge clk);
   endtask : do_op
   task automatic flag_op(input logic s, input logic [2:0] k);
      fl[k] = s;
      do_op(s ? OP_FLAG_SET : OP_FLAG_CLEAR, 5'h00, 2'h0, k, 16'h0000, 6'h00, 5'h00);
   endtask : flag_op
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {clk, rst_n, op_valid, rf_we, op_code, reg_sel, io_addr, rf_waddr, rf_raddr} = '0;
      {ptr_sel, disp, addr, bit_sel, rf_wdata, fl} = '0;
      {mismatches, n_compared, cycles} = '0;
      lfsr_q = 32'd67472;
      for (int i = 0; i < 32; i++) begin
         rm[i]  = 8'h00;
         iom[i] = 8'ha0 ^ 8'(i);
      end
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Pointer stores: X carries across the pair, Y borrows, Z keeps its value
      v = rnd();
      wr_reg(5'd5, v);
      wr_reg(5'd26, 8'hff);
      wr_reg(5'd27, 8'h01);
      q_dm.push_back({1'b1, 16'h01ff, v});
      do_op(OP_IND_POSTINC, 5'd5, 2'd1, 3'd0, 16'h0000, 6'h00, 5'h00);
      rm[26] = 8'h00;
      rm[27] = 8'h02;
      chk_reg(5'd26);
      chk_reg(5'd27);
      wr_reg(5'd29, 8'h03);
      q_dm.push_back({1'b1, 16'h02ff, v});
      do_op(OP_IND_PREDEC, 5'd5, 2'd2, 3'd0, 16'h0000, 6'h00, 5'h00);
      rm[28] = 8'hff;
      rm[29] = 8'h02;
      chk_reg(5'd28);
      chk_reg(5'd29);
      wr_reg(5'd31, 8'h01);
      q_dm.push_back({1'b1, 16'h013f, v});
      do_op(OP_OFFSET_WRITE, 5'd5, 2'd3, 3'd0, 16'h0000, 6'h3f, 5'h00);
      chk_reg(5'd30);
      q_dm.push_back({1'b1, 16'h0100, v});
      do_op(OP_IND_WRITE, 5'd5, 2'd3, 3'd0, 16'h0000, 6'h00, 5'h00);
      a = {rnd(), rnd()};
      q_dm.push_back({1'b1, a, v});
      do_op(OP_DIRECT_WRITE, 5'd5, 2'd0, 3'd0, a, 6'h00, 5'h00);
      // Stack round trip into another register
      q_dm.push_back({1'b1, 16'h00ff, v});
      do_op(OP_PUSH, 5'd5, 2'd0, 3'd0, 16'h0000, 6'h00, 5'h00);
      q_dm.push_back({1'b0, 16'h00ff, 8'h00});
      do_op(OP_POP, 5'd9, 2'd0, 3'd0, 16'h0000, 6'h00, 5'h00);
      rm[9] = v;
      chk_reg(5'd9);
      // I/O bit set then clear on a random register and bit
      t = rnd();
      b = t[2:0];
      iom[t[7:3]][b] = 1'b1;
      q_io.push_back({t[7:3], iom[t[7:3]]});
      do_op(OP_IO_BIT_SET, 5'd0, 2'd0, b, 16'h0000, 6'h00, t[7:3]);
      iom[t[7:3]][b] = 1'b0;
      q_io.push_back({t[7:3], iom[t[7:3]]});
      do_op(OP_IO_BIT_CLEAR, 5'd0, 2'd0, b, 16'h0000, 6'h00, t[7:3]);
      // Every flag set and cleared alone, with the others in varied states
      for (int k = 0; k < 8; k++) begin
         flag_op(1'b1, 3'(k));
      end
      for (int k = 0; k < 8; k++) begin
         flag_op(1'b0, 3'(k));
      end
      flag_op(1'b1, 3'd4);
      flag_op(1'b1, 3'd5);
      // Shifts and rotates on random data with random carry
      for (int n = 0; n < 40; n++) begin
         u = rnd();
         wr_reg(5'd3, u);
         flag_op(u[5] ^ u[2], 3'd0);
         rm[3] = shift_model(5'(OP_SHL_ZERO) + 5'(n % 5), u);
         do_op(5'(OP_SHL_ZERO) + 5'(n % 5), 5'd3, 2'd0, 3'd0, 16'h0000, 6'h00, 5'h00);
         chk_reg(5'd3);
      end
      // Bit transfer flag in both directions
      for (int n = 0; n < 6; n++) begin
         t = rnd();
         u = rnd();
         wr_reg(5'd7, t);
         fl[`DMBO_FLG_T] = t[u[2:0]];
         do_op(OP_BIT_TO_T, 5'd7, 2'd0, u[2:0], 16'h0000, 6'h00, 5'h00);
         wr_reg(5'd8, ~t);
         rm[8][u[5:3]] = fl[`DMBO_FLG_T];
         do_op(OP_T_TO_BIT, 5'd8, 2'd0, u[5:3], 16'h0000, 6'h00, 5'h00);
         chk_reg(5'd8);
      end
      do_op(OP_WDOG_RESTART, 5'd0, 2'd0, 3'd0, 16'h0000, 6'h00, 5'h00);
      tally_and_finish();
   end
endmodule : dmbo_exec_tb_top
